// file: spi_sel_map.svh
// register offsets, field positions and reset values of the select block
// assumes: included by bare name into the design file after the package
`ifndef SPI_SEL_MAP_SVH
`define SPI_SEL_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_MODE 8'h04
`define OFF_RDR 8'h08
`define OFF_THW 8'h0c
`define OFF_STAT 8'h10
`define OFF_CFG_HI 4'h3

// ----------------------------------------
// control register bits
// ----------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_DIS_BIT 1
`define CTRL_LAST_BIT 24

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MODE_VAR_BIT 1
`define MODE_DEC_BIT 2
`define MODE_SEL_LSB 16
`define MODE_BCS_LSB 24
`define MODE_RESET 32'h0000_0000

// ----------------------------------------
// transmit word fields
// ----------------------------------------
`define THW_SEL_LSB 16
`define THW_LAST_BIT 24

// ----------------------------------------
// per-select configuration fields
// ----------------------------------------
`define CFG_FORCE_BIT 2
`define CFG_HOLD_BIT 3
`define CFG_BITS_LSB 4
`define CFG_DIV_LSB 8
`define CFG_IWD_LSB 24
`define CFG_RESET 32'h0000_0000

// ----------------------------------------
// status register bits
// ----------------------------------------
`define STAT_HE_BIT 1
`define STAT_TI_BIT 9
`define STAT_EN_BIT 16

`define SEL_IDLE 4'hf
`define MIN_BITS 5'd8
`define MAX_BITS 5'd16

`endif

// file: spi_sel_pkg.sv
// types shared by the select block
// assumes: compiled before the design file
package spi_sel_pkg;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_GAP   = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_WDLY  = 4'b1000
  } sel_state_e;

endpackage : spi_sel_pkg

// file: spi_master_peripheral_select.sv
// spi master select control: apb registers, select sequencing, word shifter
// assumes: apb3 master on pclk, miso from a foreign domain, slaves on sel lines
`timescale 1ns/10ps
`include "spi_sel_map.svh"

module spi_master_peripheral_select
  import spi_sel_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  output logic [3:0] peripheral_select_n,
  // dma request follows the holding empty flag
  output logic tx_dma_req
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] mode_q;
  logic [31:0] cfg_q [4];
  logic [31:0] thw_q;
  logic thw_full_q;
  // registered copy of the empty flag so the dma request comes from a flop
  logic thw_empty_q;
  logic enabled_q;
  logic last_req_q;
  logic [15:0] rdr_q;
  sel_state_e state_q;
  logic [3:0] sel_n_q;
  logic sel_on_q;
  logic [3:0] cur_lines_q;
  logic [1:0] cur_cfg_q;
  logic last_word_q;
  logic [7:0] cnt_q;
  logic [4:0] bit_q;
  logic [15:0] sh_q;
  logic [15:0] rx_q;
  logic sclk_q;
  logic mosi_q;
  logic miso_m_q;
  logic miso_s_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire access = psel & penable;
  wire wr_done = access & pready_q & pwrite;
  wire hit_ctrl = paddr == `OFF_CTRL;
  wire hit_mode = paddr == `OFF_MODE;
  wire hit_rdr = paddr == `OFF_RDR;
  wire hit_thw = paddr == `OFF_THW;
  wire hit_stat = paddr == `OFF_STAT;
  wire hit_cfg = (paddr[7:4] == `OFF_CFG_HI) & (paddr[1:0] == 2'b00);
  wire [1:0] cfg_idx = paddr[3:2];
  wire rd_ok = hit_mode | hit_rdr | hit_stat | hit_cfg;
  wire wr_ok = hit_ctrl | hit_mode | hit_thw | hit_cfg;
  wire map_ok = pwrite ? wr_ok : rd_ok;
  wire wr_ctrl = wr_done & hit_ctrl;
  wire wr_thw = wr_done & hit_thw;
  wire wr_en = wr_ctrl & pwdata[`CTRL_EN_BIT];
  wire wr_dis = wr_ctrl & pwdata[`CTRL_DIS_BIT];
  wire wr_last = wr_ctrl & pwdata[`CTRL_LAST_BIT];
  wire tx_idle = (state_q == ST_IDLE) & ~thw_full_q;
  // status: holding empty, transmitter idle, enabled
  wire [31:0] stat_word = {15'h0000, enabled_q, 6'h00, tx_idle, 7'h00,
                           ~thw_full_q, 1'b0};
  wire [31:0] rd_word = hit_mode ? mode_q :
                        hit_rdr ? {16'h0000, rdr_q} :
                        hit_stat ? stat_word :
                        hit_cfg ? cfg_q[cfg_idx] : 32'h0000_0000;

  // ----------------------------------------
  // next word target
  // ----------------------------------------
  wire var_mode = mode_q[`MODE_VAR_BIT];
  wire dec_mode = mode_q[`MODE_DEC_BIT];
  // word fields are ignored in fixed mode
  wire [3:0] raw_sel = var_mode ? thw_q[`THW_SEL_LSB +: 4]
                                : mode_q[`MODE_SEL_LSB +: 4];
  // lowest zero bit wins so at most one line goes low
  wire [1:0] low_idx = ~raw_sel[0] ? 2'd0 :
                       ~raw_sel[1] ? 2'd1 :
                       ~raw_sel[2] ? 2'd2 : 2'd3;
  wire [3:0] one_low = ~(4'h1 << low_idx);
  // decode mode passes the raw code; an all-ones code looks idle
  wire [3:0] nxt_lines = dec_mode ? raw_sel : one_low;
  wire [1:0] nxt_cfg = dec_mode ? raw_sel[3:2] : low_idx;
  wire nxt_last = var_mode & thw_q[`THW_LAST_BIT];
  wire [31:0] ncfg = cfg_q[nxt_cfg];
  wire [31:0] ccfg = cfg_q[cur_cfg_q];

  // bit counts above sixteen are clamped to sixteen
  wire [4:0] nbits_raw = {1'b0, ncfg[`CFG_BITS_LSB +: 4]} + `MIN_BITS;
  wire [4:0] nbits = (nbits_raw > `MAX_BITS) ? `MAX_BITS : nbits_raw;
  wire [4:0] cbits_raw = {1'b0, ccfg[`CFG_BITS_LSB +: 4]} + `MIN_BITS;
  wire [4:0] cbits = (cbits_raw > `MAX_BITS) ? `MAX_BITS : cbits_raw;
  wire [7:0] ndiv = (ncfg[`CFG_DIV_LSB +: 8] == 8'h00) ? 8'h01 : ncfg[`CFG_DIV_LSB +: 8];
  wire [7:0] cdiv = (ccfg[`CFG_DIV_LSB +: 8] == 8'h00) ? 8'h01 : ccfg[`CFG_DIV_LSB +: 8];
  // only the low data bits shift; width of the bus write does not matter
  wire [15:0] ndata = thw_q[15:0] << (5'd16 - nbits);
  // hold and force deselect come from the config of the word in flight
  wire hold = ccfg[`CFG_HOLD_BIT];
  wire force_gap = ccfg[`CFG_FORCE_BIT] & ~hold;
  wire end_frame = last_word_q | last_req_q | ~enabled_q;
  wire can_load = thw_full_q & enabled_q;
  wire same_sel = nxt_lines == cur_lines_q;
  wire keep_sel = same_sel & ~force_gap & ~end_frame;
  wire load_idle = can_load & (~sel_on_q | same_sel);
  wire half_tick = cnt_q == 8'h00;
  wire last_edge = sclk_q & (bit_q == cbits - 5'd1);

  // ----------------------------------------
  // apb answer: one wait cycle, then ready
  // ----------------------------------------
  // registered ready costs a wait state but keeps decode off the ready path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~map_ok;
      prdata_q <= (access & ~pready_q & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // disable leaves mode and configs as they are
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `MODE_RESET;
      cfg_q <= '{default: `CFG_RESET};
      enabled_q <= 1'b0;
    end else if (ce) begin
      if (wr_done & hit_mode) begin
        mode_q <= pwdata;
      end
      if (wr_done & hit_cfg) begin
        cfg_q[cfg_idx] <= pwdata;
      end
      if (wr_dis) begin
        enabled_q <= 1'b0;
      end else if (wr_en) begin
        enabled_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // miso synchroniser
  // ----------------------------------------
  // only the second flop feeds the shifter; the first may be metastable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else if (ce) begin
      miso_m_q <= miso;
      miso_s_q <= miso_m_q;
    end
  end

  // ----------------------------------------
  // select sequencer and shifter
  // ----------------------------------------
  // holding word and last request: a new write wins over the consuming clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      thw_q <= 32'h0000_0000;
      thw_full_q <= 1'b0;
      thw_empty_q <= 1'b1;
      last_req_q <= 1'b0;
      sel_n_q <= `SEL_IDLE;
      sel_on_q <= 1'b0;
      cur_lines_q <= `SEL_IDLE;
      cur_cfg_q <= 2'd0;
      last_word_q <= 1'b0;
      cnt_q <= 8'h00;
      bit_q <= 5'd0;
      sh_q <= 16'h0000;
      rx_q <= 16'h0000;
      rdr_q <= 16'h0000;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (load_idle) begin
            state_q <= ST_SHIFT;
          end else if (can_load) begin
            // another select is held: drop it first
            sel_n_q <= `SEL_IDLE;
            sel_on_q <= 1'b0;
            cnt_q <= mode_q[`MODE_BCS_LSB +: 8];
            state_q <= ST_GAP;
          end else if (sel_on_q & (~enabled_q | last_req_q)) begin
            sel_n_q <= `SEL_IDLE;
            sel_on_q <= 1'b0;
          end
        end
        // select stays released for the between-selects delay
        ST_GAP: begin
          cnt_q <= cnt_q - 8'h01;
          if (half_tick & can_load) begin
            state_q <= ST_SHIFT;
          end else if (half_tick) begin
            state_q <= ST_IDLE;
          end
        end
        // rising half samples miso, falling half shifts mosi
        ST_SHIFT: begin
          cnt_q <= cnt_q - 8'h01;
          if (half_tick) begin
            cnt_q <= cdiv - 8'h01;
            sclk_q <= ~sclk_q;
            if (~sclk_q) begin
              rx_q <= {rx_q[14:0], miso_s_q};
            end else if (last_edge) begin
              rdr_q <= rx_q;
              cnt_q <= ccfg[`CFG_IWD_LSB +: 8];
              state_q <= ST_WDLY;
            end else begin
              sh_q <= {sh_q[14:0], 1'b0};
              mosi_q <= sh_q[14];
              bit_q <= bit_q + 5'd1;
            end
          end
        end
        // word end: keep, swap or release the select
        ST_WDLY: begin
          cnt_q <= cnt_q - 8'h01;
          if (half_tick) begin
            if (can_load & keep_sel) begin
              state_q <= ST_SHIFT;
            end else if (can_load) begin
              sel_n_q <= `SEL_IDLE;
              sel_on_q <= 1'b0;
              cnt_q <= mode_q[`MODE_BCS_LSB +: 8];
              state_q <= ST_GAP;
            end else begin
              // held only by the hold bit and not at a frame end
              if (~hold | end_frame) begin
                sel_n_q <= `SEL_IDLE;
                sel_on_q <= 1'b0;
              end
              state_q <= ST_IDLE;
            end
            last_word_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          sel_n_q <= `SEL_IDLE;
          sel_on_q <= 1'b0;
        end
      endcase
      // word load: holding register moves into the shifter
      if (((state_q == ST_IDLE) & load_idle) | ((state_q == ST_GAP) & half_tick & can_load) |
          ((state_q == ST_WDLY) & half_tick & can_load & keep_sel)) begin
        thw_full_q <= 1'b0;
        thw_empty_q <= 1'b1;
        sh_q <= ndata;
        // short words leave zeros above their bits in the receive word
        rx_q <= 16'h0000;
        mosi_q <= ndata[15];
        sel_n_q <= nxt_lines;
        sel_on_q <= 1'b1;
        cur_lines_q <= nxt_lines;
        cur_cfg_q <= nxt_cfg;
        last_word_q <= nxt_last;
        cnt_q <= ndiv - 8'h01;
        bit_q <= 5'd0;
        sclk_q <= 1'b0;
      end
      if ((state_q == ST_WDLY) & half_tick) begin
        last_req_q <= 1'b0;
      end else if ((state_q == ST_IDLE) & sel_on_q & last_req_q & ~can_load) begin
        last_req_q <= 1'b0;
      end
      if (wr_last) begin
        last_req_q <= 1'b1;
      end
      if (wr_thw) begin
        thw_q <= pwdata;
        thw_full_q <= 1'b1;
        thw_empty_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // outputs straight from flops
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sclk = sclk_q;
  assign mosi = mosi_q;
  assign peripheral_select_n = sel_n_q;
  assign tx_dma_req = thw_empty_q;  // dma asks while the holding word can take a write

endmodule : spi_master_peripheral_select

// file: spi_sel_sva.sv
// port checker for the select block
// assumes: bound to the design top by tb, one clock domain
`timescale 1ns/10ps
module spi_sel_sva (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial link
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic [3:0] peripheral_select_n,
  input wire logic tx_dma_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // decode mode copy
  // ----------------------------------------
  logic dec_q;
  logic done_w;
  assign done_w = psel && penable && pready && !pslverr;
  // only the decode bit of mode writes is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q <= 1'b0;
    end else if (done_w && pwrite && paddr == 8'h04) begin
      dec_q <= pwdata[2];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  busy_sel_a: assert property (sclk |-> peripheral_select_n != 4'hf)
    else $error("serial clock runs with no select");
  one_line_a: assert property (!dec_q |-> $onehot0(~peripheral_select_n))
    else $error("more than one select line low");
  swap_gap_a: assert property (!$stable(peripheral_select_n) &&
      $past(peripheral_select_n) != 4'hf |-> peripheral_select_n == 4'hf)
    else $error("select moved between targets without release");
  mosi_steady_a: assert property (sclk |-> $stable(mosi))
    else $error("data moved while serial clock high");
  flag_drop_a: assert property ($fell(tx_dma_req) |->
      $past(done_w && pwrite && paddr == 8'h0c))
    else $error("holding flag fell without a holding write");
  wait_one_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  // main scenarios
  cover property (done_w && pwrite && paddr == 8'h0c);
  cover property (dec_q && sclk);
  cover property (pslverr);
endmodule : spi_sel_sva

// file: spi_slave_model.sv
// slave side: counts frames and bits, answers with inverted data
// assumes: selects low active, sclk idles low, sampled on rise
`timescale 1ns/10ps
module spi_slave_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [3:0] peripheral_select_n,
  output logic miso
);
  int frames;
  int bits;
  logic [31:0] rx;
  logic [3:0] sel_seen;
  logic [3:0] last_q;
  logic sclk_q;
  // sclk comes from pclk flops, so pclk edges see each of its levels;
  // one process owns every counter, so no two blocks race on them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames <= 0;
      bits <= 0;
      rx <= 32'h0;
      sel_seen <= 4'hf;
      last_q <= 4'hf;
      sclk_q <= 1'b0;
      miso <= 1'b1;
    end else begin
      last_q <= peripheral_select_n;
      sclk_q <= sclk;
      if (peripheral_select_n == 4'hf) begin
        miso <= 1'b1; // released line rests at its pull-up
      end else if (last_q == 4'hf) begin
        frames <= frames + 1;
        sel_seen <= peripheral_select_n;
        bits <= 0;
        rx <= 32'h0;
      end else if (sclk && !sclk_q) begin
        bits <= bits + 1;
        rx <= {rx[30:0], mosi};
      end else if (!sclk && sclk_q) begin
        miso <= ~mosi;
      end
    end
  end
endmodule : spi_slave_model

// file: tb.sv
// self-checking bench for the select block
// assumes: package, design, checker and slave model compiled first
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sclk, mosi, miso, tx_dma_req;
  logic [3:0] peripheral_select_n;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int n_compared = 0;
  int nf = 0;
  // 40 mhz clock
  always #12.5 pclk = ~pclk;
  spi_master_peripheral_select dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk), .mosi(mosi),
    .miso(miso), .peripheral_select_n(peripheral_select_n), .tx_dma_req(tx_dma_req));
  spi_slave_model slv (.pclk(pclk), .presetn(presetn), .sclk(sclk), .mosi(mosi),
    .peripheral_select_n(peripheral_select_n), .miso(miso));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; holds the request until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // poll transmitter idle, then judge the last frame seen by the slave
  task automatic frame(input int df, input logic [3:0] s, input int b, input logic [31:0] d);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0);
      n++;
    end while (rd[9] !== 1'b1 && n < 100);
    nf += df;
    chk(rd[9], 1'b1);
    if (rd[9] !== 1'b1) begin
      end_of_test();
    end
    chk(slv.frames, nf);
    chk(slv.sel_seen, s);
    chk(slv.bits, b);
    chk(slv.rx, d);
  endtask : frame
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs();
    chk(peripheral_select_n, 4'hf);
    chk(tx_dma_req, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 8'h30, 32'h100);
    apb(1'b1, 8'h34, 32'h240);
    apb(1'b1, 8'h38, 32'h108); // hold on select 2, no mode fault logic here
    apb(1'b1, 8'h3c, 32'h180);
    apb(1'b1, 8'h00, 32'h1);
  endtask : s_regs
  task automatic s_fixed();
    logic [5:0] v;
    apb(1'b1, 8'h04, 32'h000d_0000);
    apb(1'b1, 8'h0c, 32'h000e_0abc);
    // freeze mid-word: sclk, mosi and the selects must hold while ce is low
    repeat (8) @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk);
    v = {sclk, mosi, peripheral_select_n};
    repeat (6) @(posedge pclk);
    chk({sclk, mosi, peripheral_select_n}, v);
    chk(peripheral_select_n, 4'hd);
    ce <= 1'b1;
    frame(1, 4'hd, 12, 32'habc);
    chk(peripheral_select_n, 4'hf);
    apb(1'b1, 8'h04, 32'h0008_0000);
    apb(1'b1, 8'h0c, 32'h0000_005a);
    frame(1, 4'he, 8, 32'h5a);
  endtask : s_fixed
  task automatic s_var();
    apb(1'b1, 8'h04, 32'h0000_0002);
    apb(1'b1, 8'h0c, 32'h0007_beef);
    apb(1'b1, 8'h0c, 32'h000d_0abc);
    frame(2, 4'hd, 12, 32'habc);
    apb(1'b1, 8'h0c, 32'h000e_0011);
    apb(1'b1, 8'h0c, 32'h000e_0022);
    frame(1, 4'he, 16, 32'h1122);
    apb(1'b1, 8'h30, 32'h104);
    apb(1'b1, 8'h0c, 32'h000e_0011);
    apb(1'b1, 8'h0c, 32'h000e_0022);
    frame(2, 4'he, 8, 32'h22);
    apb(1'b1, 8'h04, 32'h0000_0006);
    apb(1'b1, 8'h0c, 32'h0005_0123);
    frame(1, 4'h5, 12, 32'h123);
    apb(1'b1, 8'h04, 32'h0000_0002);
  endtask : s_var
  task automatic s_hold();
    apb(1'b1, 8'h0c, 32'h000b_0033);
    frame(1, 4'hb, 8, 32'h33);
    chk(peripheral_select_n, 4'hb);
    apb(1'b1, 8'h0c, 32'h000b_0044);
    apb(1'b1, 8'h00, 32'h0100_0000);
    frame(0, 4'hb, 16, 32'h3344);
    chk(peripheral_select_n, 4'hf);
    apb(1'b1, 8'h0c, 32'h010b_0055);
    frame(1, 4'hb, 8, 32'h55);
    chk(peripheral_select_n, 4'hf);
    apb(1'b1, 8'h0c, 32'h000b_0066);
    frame(1, 4'hb, 8, 32'h66);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[16], 1'b0);
    chk(peripheral_select_n, 4'hf);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
  endtask : s_hold
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_fixed();
    s_var();
    s_hold();
    end_of_test();
  end
endmodule : tb
bind spi_master_peripheral_select spi_sel_sva sva_i (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
  .mosi(mosi), .miso(miso), .peripheral_select_n(peripheral_select_n),
  .tx_dma_req(tx_dma_req));
